/* logic/ccs_exec.sv */
// execution of the complement and compare-skip-if-equal instructions
// Function
// - decode complement opcode, invert addressed byte, touch only N and Z
// - destination bit zero writes accumulator, one writes back the byte
// - access bit zero selects access bank, one uses bank select register
// - access zero, extended set, address up to 5Fh: indexed literal offset
// - complement is one word, one cycle: decode, read, process, write
// - compare byte with accumulator unsigned, change no flag or operand
// - on equality the fetched next instruction becomes a no-operation
// - skipped two-word instruction costs two no-operations, three cycles
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "ccs_cfg.svh"

module ccs_exec
    import ccs_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire logic [1:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        instr_valid_in,
    input  wire logic [15:0] instr_word_in,
    input  wire logic        next_two_word_in,
    input  wire logic [11:0] index_base_in,
    output logic             discard_out,
    output logic             qstart_out,
    output logic      [11:0] mem_addr_out,
    output logic             mem_rd_out,
    input  wire logic [7:0]  mem_rdata_in,
    output logic             mem_wr_out,
    output logic      [7:0]  mem_wdata_out
);

    ccs_qphase_t  q_reg;
    ccs_op_t      op_reg;
    logic         dest_reg;
    logic         acc_reg;
    logic [7:0]   f_reg;
    logic [1:0]   skip_reg;
    logic [7:0]   accum_reg;
    logic [3:0]   bank_reg;
    logic         ext_reg;
    logic         neg_reg;
    logic         zero_reg;
    logic         wait_reg;
    logic [31:0]  rdata_reg;
    logic         rd_reg;
    logic         wr_reg;
    logic [11:0]  addr_reg;
    logic [7:0]   wdata_reg;
    logic         discard_reg;
    logic         qstart_reg;
    logic [11:0]  addr_next;
    logic [7:0]   comp;
    logic         neg_next;
    logic         zero_next;
    logic         equal;
    logic         bus_wr;
    logic         issue;

    // address of the operand from the instruction being decoded
    ccs_bank_addr u_addr
    (
        .f_in          (instr_word_in[7:0]),
        .access_in     (instr_word_in[8]),
        .ext_en_in     (ext_reg),
        .bank_in       (bank_reg),
        .index_base_in (index_base_in),
        .addr_out      (addr_next)
    );

    // datapath on the byte returned in the process phase
    // unsigned compare
    ccs_alu u_alu
    (
        .data_in   (mem_rdata_in),
        .accum_in  (accum_reg),
        .comp_out  (comp),
        .neg_out   (neg_next),
        .zero_out  (zero_next),
        .equal_out (equal)
    );

    assign bus_wr = avs_write_in && !wait_reg && avs_byteenable_in[0];
    assign issue  = (q_reg == CCS_Q1) && (skip_reg == 2'd0) && instr_valid_in;

    // quarter-phase sequencer, gray along q1 q2 q3 q4
    // four quarters
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            q_reg <= CCS_Q1;
        else
        begin
            unique case (q_reg)
                CCS_Q1: q_reg <= CCS_Q2;
                CCS_Q2: q_reg <= CCS_Q3;
                CCS_Q3: q_reg <= CCS_Q4;
                CCS_Q4: q_reg <= CCS_Q1;
            endcase
        end
    end

    // decode in q1, retire after q4
    // opcode decode
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            op_reg   <= CCS_OP_NONE;
            dest_reg <= 1'b1;
            acc_reg  <= 1'b1;
            f_reg    <= 8'h00;
        end
        else if (issue)
        begin
            dest_reg <= instr_word_in[9];
            acc_reg  <= instr_word_in[8];
            f_reg    <= instr_word_in[7:0];
            if (instr_word_in[15:10] == `CCS_OPC_COMP)
                op_reg <= CCS_OP_COMP;
            else if (instr_word_in[15:9] == `CCS_OPC_CMP)
                op_reg <= CCS_OP_CMP;
            else
                op_reg <= CCS_OP_NONE;
        end
        else if (q_reg == CCS_Q4)
            op_reg <= CCS_OP_NONE;
    end

    // read strobe stands in q2, address held through the cycle
    // bank choice
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rd_reg   <= 1'b0;
            addr_reg <= 12'h000;
        end
        else if (issue)
        begin
            rd_reg   <= (instr_word_in[15:10] == `CCS_OPC_COMP) ||
                        (instr_word_in[15:9] == `CCS_OPC_CMP);
            addr_reg <= addr_next;
        end
        else
            rd_reg <= 1'b0;
    end

    // write-back strobe stands in q4
    // file destination
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wr_reg    <= 1'b0;
            wdata_reg <= 8'h00;
        end
        else if ((q_reg == CCS_Q3) && (op_reg == CCS_OP_COMP) && dest_reg)
        begin
            wr_reg    <= 1'b1;
            wdata_reg <= comp;
        end
        else
            wr_reg <= 1'b0;
    end

    // accumulator: core result wins over a bus write in the same edge
    // accumulator destination
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            accum_reg <= `CCS_RST_ACCUM;
        else if ((q_reg == CCS_Q3) && (op_reg == CCS_OP_COMP) && !dest_reg)
            accum_reg <= comp;
        else if (bus_wr && (avs_address_in == `CCS_OFS_ACCUM))
            accum_reg <= avs_writedata_in[7:0];
    end

    // status flags, compare leaves them alone
    // flag values
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            neg_reg  <= 1'b0;
            zero_reg <= 1'b0;
        end
        else if ((q_reg == CCS_Q3) && (op_reg == CCS_OP_COMP))
        begin
            neg_reg  <= neg_next;
            zero_reg <= zero_next;
        end
    end

    // skip count loaded on equality, spent one word per q1
    // skip on equal
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            skip_reg <= 2'd0;
        else if ((q_reg == CCS_Q3) && (op_reg == CCS_OP_CMP) && equal)
            skip_reg <= next_two_word_in ? `CCS_SKIP_TWO : `CCS_SKIP_ONE;
        else if ((q_reg == CCS_Q1) && (skip_reg != 2'd0))
            skip_reg <= skip_reg - 2'd1;
    end

    // discard marker for the fetch path, one cycle per skipped word
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            discard_reg <= 1'b0;
            qstart_reg  <= 1'b0;
        end
        else
        begin
            discard_reg <= (q_reg == CCS_Q1) && (skip_reg != 2'd0);
            qstart_reg  <= (q_reg == CCS_Q4);
        end
    end

    // bank select and extended-set enable
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            bank_reg <= `CCS_RST_BANK;
            ext_reg  <= `CCS_RST_EXT;
        end
        else if (bus_wr && (avs_address_in == `CCS_OFS_BANK))
            bank_reg <= avs_writedata_in[3:0];
        else if (bus_wr && (avs_address_in == `CCS_OFS_CTRL))
            ext_reg <= avs_writedata_in[`CCS_CTRL_EXT_BIT];
    end

    // avalon slave: one wait cycle, data stands with waitrequest low
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end
        else if ((avs_read_in || avs_write_in) && wait_reg)
        begin
            wait_reg  <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            if (avs_read_in)
            begin
                unique case (avs_address_in)
                    `CCS_OFS_CTRL:   rdata_reg[`CCS_CTRL_EXT_BIT] <= ext_reg;
                    `CCS_OFS_STATUS:
                    begin
                        rdata_reg[`CCS_STAT_N_BIT] <= neg_reg;
                        rdata_reg[`CCS_STAT_Z_BIT] <= zero_reg;
                    end
                    `CCS_OFS_ACCUM:  rdata_reg[7:0] <= accum_reg;
                    `CCS_OFS_BANK:   rdata_reg[3:0] <= bank_reg;
                endcase
            end
        end
        else
            wait_reg <= 1'b1;
    end

    assign avs_readdata_out    = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign discard_out         = discard_reg;
    assign qstart_out          = qstart_reg;
    assign mem_addr_out        = addr_reg;
    assign mem_rd_out          = rd_reg;
    assign mem_wr_out          = wr_reg;
    assign mem_wdata_out       = wdata_reg;

    // checks
    sequence comp_proc_s;
        (q_reg == CCS_Q3) && (op_reg == CCS_OP_COMP);
    endsequence

    sequence cmp_eq_s;
        (q_reg == CCS_Q3) && (op_reg == CCS_OP_CMP) && equal;
    endsequence

    decode_read_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        issue && (instr_word_in[15:10] == `CCS_OPC_COMP)
        |=> mem_rd_out ##1 !mem_rd_out ##1 (mem_wr_out == dest_reg))
        else $error("complement did not read then finish");
    file_write_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        comp_proc_s and dest_reg
        |=> mem_wr_out && (mem_wdata_out == ~$past(mem_rdata_in)))
        else $error("complement write-back wrong");
    accum_write_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        comp_proc_s and !dest_reg
        |=> !mem_wr_out && (accum_reg == ~$past(mem_rdata_in)))
        else $error("complement accumulator result wrong");
    bank_addr_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        mem_rd_out && acc_reg |-> mem_addr_out == {bank_reg, f_reg})
        else $error("banked address wrong");
    index_addr_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        issue && ext_reg && !instr_word_in[8] &&
        (instr_word_in[7:0] <= `CCS_IDX_LIMIT)
        |=> mem_addr_out == $past(index_base_in) + {4'h0, f_reg})
        else $error("indexed literal offset address wrong");
    phase_strobe_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (mem_rd_out |-> q_reg == CCS_Q2) and (mem_wr_out |-> q_reg == CCS_Q4))
        else $error("strobe in wrong quarter");
    cmp_keeps_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        (q_reg == CCS_Q3) && (op_reg == CCS_OP_CMP)
        |=> $stable(neg_reg) && $stable(zero_reg) && !mem_wr_out)
        else $error("compare changed state");
    skip_one_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        cmp_eq_s and !next_two_word_in
        |-> ##3 discard_out ##1 !discard_out [*4])
        else $error("single skip wrong");
    skip_two_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        cmp_eq_s and next_two_word_in
        |-> ##3 discard_out ##1 !discard_out [*3] ##1 discard_out
        ##1 !discard_out [*4])
        else $error("double skip wrong");
    comp_flags_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        comp_proc_s |=> (neg_reg == ~$past(mem_rdata_in[7])) &&
        (zero_reg == ($past(mem_rdata_in) == 8'hFF)))
        else $error("complement flags wrong");

endmodule : ccs_exec

/* pkg/ccs_cfg.svh */
// offsets, field positions, reset values and opcode patterns
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH

`define CCS_OFS_CTRL      2'h0
`define CCS_OFS_STATUS    2'h1
`define CCS_OFS_ACCUM     2'h2
`define CCS_OFS_BANK      2'h3

`define CCS_CTRL_EXT_BIT  0
`define CCS_STAT_Z_BIT    0
`define CCS_STAT_N_BIT    1

`define CCS_RST_ACCUM     8'h00
`define CCS_RST_BANK      4'h0
`define CCS_RST_EXT       1'b0

`define CCS_OPC_COMP      6'b00_0111
`define CCS_OPC_CMP       7'b011_0001
`define CCS_IDX_LIMIT     8'h5F
`define CCS_ACC_HI_BANK   4'hF
`define CCS_SKIP_ONE      2'd1
`define CCS_SKIP_TWO      2'd2

`endif

/* pkg/ccs_pkg.sv */
// types shared by the complement and compare-skip execution logic
package ccs_pkg;

    typedef enum logic [1:0]
    {
        CCS_Q1 = 2'b00,
        CCS_Q2 = 2'b01,
        CCS_Q3 = 2'b11,
        CCS_Q4 = 2'b10
    } ccs_qphase_t;

    typedef enum logic [1:0]
    {
        CCS_OP_NONE = 2'b00,
        CCS_OP_COMP = 2'b01,
        CCS_OP_CMP  = 2'b11
    } ccs_op_t;

endpackage : ccs_pkg

/* logic/ccs_bank_addr.sv */
// operand address resolution for byte-oriented instructions
`timescale 1ns/1ps
`include "ccs_cfg.svh"

module ccs_bank_addr
    import ccs_pkg::*;
(
    input  wire logic [7:0]  f_in,
    input  wire logic        access_in,
    input  wire logic        ext_en_in,
    input  wire logic [3:0]  bank_in,
    input  wire logic [11:0] index_base_in,
    output logic      [11:0] addr_out
);

    // banked, indexed or access-bank address
    always_comb
    begin
        if (access_in)
            addr_out = {bank_in, f_in};
        else if (ext_en_in && (f_in <= `CCS_IDX_LIMIT))
            addr_out = index_base_in + {4'h0, f_in};
        else if (f_in <= `CCS_IDX_LIMIT)
            addr_out = {4'h0, f_in};
        else
            addr_out = {`CCS_ACC_HI_BANK, f_in};
    end

endmodule : ccs_bank_addr

/* logic/ccs_alu.sv */
// complement and unsigned compare datapath
`timescale 1ns/1ps

module ccs_alu
    import ccs_pkg::*;
(
    input  wire logic [7:0] data_in,
    input  wire logic [7:0] accum_in,
    output logic      [7:0] comp_out,
    output logic            neg_out,
    output logic            zero_out,
    output logic            equal_out
);

    logic [8:0] diff;

    // inverse and its flags
    assign comp_out = ~data_in;
    assign neg_out  = comp_out[7];
    assign zero_out = (comp_out == 8'h00);

    // unsigned subtraction, equal when the difference is zero
    assign diff      = {1'b0, data_in} - {1'b0, accum_in};
    assign equal_out = (diff[7:0] == 8'h00);

endmodule : ccs_alu

/* verif/ccs_mem_model.sv */
// banked data memory model answering the operand strobes
`timescale 1ns/1ps

module ccs_mem_model
(
    input  wire logic        sys_clk_in,
    input  wire logic [11:0] addr_in,
    input  wire logic        rd_in,
    input  wire logic        wr_in,
    input  wire logic [7:0]  wdata_in,
    output logic      [7:0]  rdata_out
);
    logic [7:0] mem [0:4095];
    logic [7:0] last_reg = 8'h00;

    // byte shows only in Q3; otherwise the inverse of the last byte
    always @(posedge sys_clk_in)
    begin
        rdata_out <= rd_in ? mem[addr_in] : ~last_reg;
        last_reg  <= rd_in ? mem[addr_in] : last_reg;
    end

    // write strobe stores the byte; the bench preloads bytes too
    always @(posedge sys_clk_in)
    begin
        if (wr_in)
        begin
            mem[addr_in] <= wdata_in;
        end
    end
endmodule : ccs_mem_model

/* verif/complement_and_compare_skip_ops_bench.sv */
// self-checking bench for the complement and compare-skip block
`timescale 1ns/1ps

module complement_and_compare_skip_ops_bench;
    logic        clk, rstn, rd, wr, wt, valid, two, disc, qst, mrd, mwr;
    logic [1:0]  adr;
    logic [3:0]  be;
    logic [7:0]  mrdata, mwdata;
    logic [11:0] base, maddr;
    logic [15:0] word;
    logic [31:0] wdat, rdat, q;
    int          mismatches, num_checks;

    ccs_exec u_ccs_exec (.sys_clk_in(clk), .rstn_in(rstn),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdat), .avs_byteenable_in(be),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
        .instr_valid_in(valid), .instr_word_in(word),
        .next_two_word_in(two), .index_base_in(base),
        .discard_out(disc), .qstart_out(qst), .mem_addr_out(maddr),
        .mem_rd_out(mrd), .mem_rdata_in(mrdata), .mem_wr_out(mwr),
        .mem_wdata_out(mwdata));

    ccs_mem_model u_ccs_mem_model (.sys_clk_in(clk), .addr_in(maddr),
        .rd_in(mrd), .wr_in(mwr), .wdata_in(mwdata), .rdata_out(mrdata));

    // free-running core clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [1:0] a,
                       input logic [31:0] d, input logic [3:0] e,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        rd   <= ~w;
        wr   <= w;
        adr  <= a;
        wdat <= d;
        be   <= e;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wt !== 1'b0 && n < 20);
        check("bus answer", n < 20, 1'b1);
        r = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    // returns at the rising edge that opens a Q1 cycle
    task automatic align;
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (qst !== 1'b1 && n < 20);
        check("phase marker", n < 20, 1'b1);
        repeat (4) @(posedge clk);
    endtask : align

    // presents one word for the decode edge
    task automatic send(input logic [15:0] w);
        valid <= 1'b1;
        word  <= w;
        @(posedge clk);
        valid <= 1'b0;
    endtask : send

    task automatic reg_test;
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, i[1:0], 32'h0000_0000, 4'hF, q);
            check("reset value", q, 32'h0000_0000);
        end
        bus(1'b1, 2'h1, 32'h0000_0003, 4'hF, q);
        bus(1'b0, 2'h1, 32'h0000_0000, 4'hF, q);
        check("status read-only", q, 32'h0000_0000);
        bus(1'b1, 2'h3, 32'h0000_0005, 4'h0, q);
        bus(1'b0, 2'h3, 32'h0000_0000, 4'hF, q);
        check("masked write", q, 32'h0000_0000);
        bus(1'b1, 2'h3, 32'h0000_0005, 4'hF, q);
        bus(1'b0, 2'h3, 32'h0000_0000, 4'hF, q);
        check("bank", q, 32'h0000_0005);
        $display("test registers done");
    endtask : reg_test

    task automatic do_comp(input logic d, input logic a, input logic [7:0] f,
                           input logic [7:0] data, input logic [11:0] ea);
        logic [7:0] res;
        res = ~data;
        bus(1'b1, 2'h2, 32'h0000_005A, 4'hF, q);
        u_ccs_mem_model.mem[ea] = data;
        align();
        send({6'b00_0111, d, a, f});
        @(negedge clk);
        check("read strobe", mrd, 1'b1);
        check("operand addr", maddr, ea);
        repeat (2) @(negedge clk);
        check("write strobe", mwr, d);
        check("write data", d ? mwdata : res, res);
        repeat (2) @(posedge clk);
        check("byte", u_ccs_mem_model.mem[ea], d ? res : data);
        bus(1'b0, 2'h2, 32'h0000_0000, 4'hF, q);
        check("accum", q, d ? 8'h5A : res);
        bus(1'b0, 2'h1, 32'h0000_0000, 4'hF, q);
        check("flags", q, {res[7], res == 8'h00});
        $display("test complement at %h done", ea);
    endtask : do_comp

    task automatic do_cmp(input logic [7:0] data, input logic [7:0] acc,
                          input logic tw, input int nd);
        int cnt;
        logic [31:0] st;
        cnt = 0;
        bus(1'b1, 2'h2, {24'h00_0000, acc}, 4'hF, q);
        bus(1'b0, 2'h1, 32'h0000_0000, 4'hF, st);
        u_ccs_mem_model.mem[12'h540] = data;
        u_ccs_mem_model.mem[12'h541] = 8'h11;
        two <= tw;
        align();
        send({7'b011_0001, 1'b1, 8'h40});
        repeat (3) @(posedge clk);
        send({6'b00_0111, 2'b11, 8'h41});
        repeat (11)
        begin
            @(negedge clk);
            cnt += (disc === 1'b1);
        end
        check("discards", cnt, nd);
        check("skipped", u_ccs_mem_model.mem[12'h541], nd ? 8'h11 : 8'hEE);
        check("operand", u_ccs_mem_model.mem[12'h540], data);
        bus(1'b0, 2'h2, 32'h0000_0000, 4'hF, q);
        check("accum kept", q, acc);
        bus(1'b0, 2'h1, 32'h0000_0000, 4'hF, q);
        check("flags kept", q, nd ? st : 32'h0000_0002);
        $display("test compare %h with %h done", data, acc);
    endtask : do_cmp

    // main sequence
    initial
    begin
        mismatches = 0;
        num_checks = 0;
        rstn = 1'b0;
        {rd, wr, valid, two} = 4'h0;
        adr = 2'h0;
        be = 4'hF;
        wdat = 32'h0000_0000;
        word = 16'h0000;
        base = 12'h000;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        reg_test();
        do_comp(1'b1, 1'b1, 8'h3A, 8'h13, 12'h53A);
        do_comp(1'b0, 1'b0, 8'h20, 8'hFF, 12'h020);
        do_comp(1'b1, 1'b0, 8'h80, 8'h7F, 12'hF80);
        bus(1'b1, 2'h0, 32'h0000_0001, 4'hF, q);
        base <= 12'h300;
        do_comp(1'b0, 1'b0, 8'h5F, 8'h55, 12'h35F);
        do_comp(1'b1, 1'b0, 8'h60, 8'hC3, 12'hF60);
        do_comp(1'b1, 1'b1, 8'h10, 8'h01, 12'h510);
        do_cmp(8'h9C, 8'h9C, 1'b0, 1);
        do_cmp(8'h9C, 8'h9C, 1'b1, 2);
        do_cmp(8'h80, 8'h7F, 1'b0, 0);
        give_verdict();
    end

    // watchdog for a hung handshake
    initial
    begin
        #100000;
        mismatches++;
        give_verdict();
    end
endmodule : complement_and_compare_skip_ops_bench
